// ===== logic/mixed_pair_params.svh
// Constants for the two-pair texel decoder: bit positions, alpha values, latency.
// Assumes a 128-bit compressed block with texel selects in the low 64 bits.
// Function
// - Block is two-pair format when its top bit is one.
// - Four 5-bit RGB colours, colour 3 at top, colour 0 ending at bit 64.
// - Texel n uses a 2-bit select at bits 2n+1 down to 2n.
// - Texels 0-15 use colours 0,1; texels 16-31 use colours 2,3.
// - Bit 124 picks the decode variant and feeds no colour channel.
// - Flag clear: all 5:6:5, colour 3 LSB bit 126, colour 1 LSB bit 125.
// - Flag clear: colour 2 LSB is 33 xor 126, colour 0 LSB 1 xor 125.
// - Expand 5-bit by replicating top three bits, 6-bit green by top two.
// - Flag clear low table: c0, (2c0+c1+1)/3, (c0+2c1+1)/3, c1, opaque.
// - Flag clear high table: c2, two thirds mix, one third mix, c3, opaque.
// - Flag set: colours 0,2 are 5:5:5; colours 1,3 5:6:5 with direct LSBs.
// - Flag set low table: c0, average, c1, transparent black.
// - Flag set high table: c2, average, c3, transparent black.
// - Output is 32-bit alpha, red, green, blue, eight bits each.
// - Every colour is opaque except the transparent black entries.
`ifndef MIXED_PAIR_PARAMS_SVH
`define MIXED_PAIR_PARAMS_SVH

`define FMT_MODE_BIT     127
`define C3_GLSB_BIT      126
`define C1_GLSB_BIT      125
`define ALPHA_FLAG_BIT   124
`define C2_GXOR_BIT      33
`define C0_GXOR_BIT      1
`define COL0_LSB         64
`define COL_STRIDE       15
`define BLUE_OFS         0
`define GREEN_OFS        5
`define RED_OFS          10
`define PAIR_SEL_BIT     4
`define SEL_BLACK        2'h3
`define ALPHA_OPAQUE     8'hFF
`define ALPHA_CLEAR      8'h00
`define DECODE_LATENCY   2

`endif

// ===== logic/mixed_pair_pkg.sv
// Types shared by the two-pair texel decoder.
// Assumes nothing beyond the constants header.
package mixed_pair_pkg;
    typedef logic [7:0]   chan_t;
    typedef logic [23:0]  rgb_t;
    typedef logic [31:0]  argb_t;
    typedef logic [127:0] block_t;
    typedef logic [4:0]   texel_t;
    typedef logic [1:0]   sel_t;
endpackage : mixed_pair_pkg

// ===== logic/color_unpack.sv
// Expands one packed 5:5:5 or 5:6:5 colour to 8 bits per channel.
// Combinational; the caller registers the result.
`timescale 1ns/1ps
module color_unpack
    import mixed_pair_pkg::*;
(
    input  wire logic [4:0]         red5,
    input  wire logic [4:0]         grn5,
    input  wire logic [4:0]         blu5,
    input  wire logic               grn_lsb,
    input  wire logic               wide_green,
    output mixed_pair_pkg::rgb_t    rgb
);
    import mixed_pair_pkg::*;

    chan_t red8;
    chan_t grn8;
    chan_t blu8;

    assign red8 = {red5, red5[4:2]};
    assign blu8 = {blu5, blu5[4:2]};
    assign grn8 = wide_green ? {grn5, grn_lsb, grn5[4:3]} : {grn5, grn5[4:2]};
    assign rgb  = {red8, grn8, blu8};
endmodule : color_unpack

// ===== logic/channel_mix.sv
// Per-channel blends of two base values: two rounded thirds and a midpoint.
// Combinational; inputs are 8-bit expanded channels.
`timescale 1ns/1ps
module channel_mix
    import mixed_pair_pkg::*;
(
    input  mixed_pair_pkg::chan_t   chan_a,
    input  mixed_pair_pkg::chan_t   chan_b,
    output mixed_pair_pkg::chan_t   third_a,
    output mixed_pair_pkg::chan_t   third_b,
    output mixed_pair_pkg::chan_t   midpoint
);
    import mixed_pair_pkg::*;

    logic [9:0] sum_a;
    logic [9:0] sum_b;
    logic [8:0] sum_mid;

    assign sum_a   = {1'h0, chan_a, 1'h0} + {2'h0, chan_b} + 10'h001;
    assign sum_b   = {2'h0, chan_a} + {1'h0, chan_b, 1'h0} + 10'h001;
    assign third_a = 8'(sum_a / 10'h003);
    assign third_b = 8'(sum_b / 10'h003);
    assign sum_mid  = {1'h0, chan_a} + {1'h0, chan_b};
    assign midpoint = sum_mid[8:1];
endmodule : channel_mix

// ===== logic/mixed_pair_texel_decoder.sv
// Two-pair compressed block decoder: one texel colour per request, two-cycle latency.
// Assumes requests synchronous to core_clk; a new request may come every cycle.
`timescale 1ns/1ps
`include "mixed_pair_params.svh"
module mixed_pair_texel_decoder
    import mixed_pair_pkg::*;
(
    input  wire logic               core_clk,
    input  wire logic               sys_rst,
    input  wire logic               in_valid,
    input  mixed_pair_pkg::block_t  in_block,
    input  mixed_pair_pkg::texel_t  in_texel,
    output logic                    out_valid,
    output mixed_pair_pkg::argb_t   out_argb,
    output logic                    out_fmt_ok
);
    import mixed_pair_pkg::*;

    // Selects the 2-bit index of one texel
    function automatic sel_t texel_sel(input block_t blk, input texel_t n);
        texel_sel = blk[{n, 1'h0} +: 2];
    endfunction : texel_sel

    // Request stage
    logic    vld_r;
    block_t  blk_r;
    texel_t  texel_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            vld_r   <= 1'h0;
            blk_r   <= '0;
            texel_r <= '0;
        end else begin
            vld_r <= in_valid;
            if (in_valid) begin
                blk_r   <= in_block;
                texel_r <= in_texel;
            end
        end
    end

    wire  is_two_pair = blk_r[`FMT_MODE_BIT];
    // variant flag, used only as a steering bit
    wire  alpha_flag  = blk_r[`ALPHA_FLAG_BIT];

    logic [3:0] glsb;
    logic [3:0] wide_g;
    assign glsb[3]   = blk_r[`C3_GLSB_BIT];
    assign glsb[1]   = blk_r[`C1_GLSB_BIT];
    assign glsb[2]   = blk_r[`C2_GXOR_BIT] ^ blk_r[`C3_GLSB_BIT];
    assign glsb[0]   = blk_r[`C0_GXOR_BIT] ^ blk_r[`C1_GLSB_BIT];
    assign wide_g[3] = 1'h1;
    assign wide_g[1] = 1'h1;
    assign wide_g[2] = ~alpha_flag;
    assign wide_g[0] = ~alpha_flag;

    rgb_t col [4];
    for (genvar i = 0; i < 4; i++) begin : g_col
        localparam int BASE = `COL0_LSB + `COL_STRIDE * i;
        color_unpack u_unpack (
            .red5       (blk_r[BASE + `RED_OFS +: 5]),
            .grn5       (blk_r[BASE + `GREEN_OFS +: 5]),
            .blu5       (blk_r[BASE + `BLUE_OFS +: 5]),
            .grn_lsb    (glsb[i]),
            .wide_green (wide_g[i]),
            .rgb        (col[i])
        );
    end

    // pick the colour pair by texel half
    wire   upper_half = texel_r[`PAIR_SEL_BIT];
    rgb_t  pair_a;
    rgb_t  pair_b;
    assign pair_a = upper_half ? col[2] : col[0];
    assign pair_b = upper_half ? col[3] : col[1];

    // both halves share one blend path
    rgb_t mix_ta;
    rgb_t mix_tb;
    rgb_t mix_mid;
    for (genvar j = 0; j < 3; j++) begin : g_chan
        channel_mix u_mix (
            .chan_a   (pair_a[8*j +: 8]),
            .chan_b   (pair_b[8*j +: 8]),
            .third_a  (mix_ta[8*j +: 8]),
            .third_b  (mix_tb[8*j +: 8]),
            .midpoint (mix_mid[8*j +: 8])
        );
    end

    sel_t  sel;
    assign sel = texel_sel(blk_r, texel_r);

    rgb_t  rgb_thirds;
    assign rgb_thirds = (sel == 2'h0) ? pair_a :
                        (sel == 2'h1) ? mix_ta :
                        (sel == 2'h2) ? mix_tb : pair_b;

    // midpoint table with black at index 3
    rgb_t  rgb_mid;
    assign rgb_mid = (sel == 2'h0) ? pair_a :
                     (sel == 2'h1) ? mix_mid :
                     (sel == 2'h2) ? pair_b : 24'h000000;

    // only the flagged black entry is transparent
    wire   is_clear = alpha_flag && (sel == `SEL_BLACK);
    chan_t alpha_val;
    assign alpha_val = is_clear ? `ALPHA_CLEAR : `ALPHA_OPAQUE;

    // pack alpha, red, green, blue; other formats give zero
    argb_t argb_nxt;
    assign argb_nxt = is_two_pair ? {alpha_val, alpha_flag ? rgb_mid : rgb_thirds} : 32'h00000000;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            out_valid  <= 1'h0;
            out_argb   <= '0;
            out_fmt_ok <= 1'h0;
        end else begin
            out_valid <= vld_r;
            if (vld_r) begin
                out_argb   <= argb_nxt;
                out_fmt_ok <= is_two_pair;
            end
        end
    end

    // Checks
    // answer two cycles on
    chk_fixed_latency: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        in_valid |-> ##2 out_valid)
        else $error("answer not two cycles after request");

    chk_no_spurious: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        out_valid |-> $past(in_valid, 2))
        else $error("answer without request");

    chk_other_format: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && !is_two_pair |=> out_valid && !out_fmt_ok && out_argb == 32'h00000000)
        else $error("non two-pair block not flagged");

    chk_alpha_opaque: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && !is_clear |=> out_argb[31:24] == `ALPHA_OPAQUE)
        else $error("alpha not opaque");

    chk_black_entry: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && alpha_flag && sel == `SEL_BLACK |=> out_argb == 32'h00000000)
        else $error("index 3 not transparent black");

    chk_low_pair_base: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && !upper_half && sel == 2'h0 |=> out_argb[23:0] == $past(col[0]))
        else $error("low texel not from colour 0");

    chk_high_pair_end: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && upper_half && !alpha_flag && sel == 2'h3
        |=> out_argb[23:0] == $past(col[3]))
        else $error("high index 3 not colour 3");

    chk_green_xor: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && !alpha_flag
        |-> col[0][10] == (blk_r[`C0_GXOR_BIT] ^ blk_r[`C1_GLSB_BIT])
            && col[2][10] == (blk_r[`C2_GXOR_BIT] ^ blk_r[`C3_GLSB_BIT]))
        else $error("derived green bit wrong");

    chk_plain_555: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && alpha_flag |-> col[0][10:8] == col[0][15:13] && col[1][10] == blk_r[`C1_GLSB_BIT])
        else $error("flag-set colour expansion wrong");

    chk_third_round: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && !alpha_flag && sel == 2'h1
        |=> 3 * 32'(out_argb[7:0]) <= 2 * 32'($past(pair_a[7:0])) + 32'($past(pair_b[7:0])) + 1
            && 3 * 32'(out_argb[7:0]) + 3 > 2 * 32'($past(pair_a[7:0])) + 32'($past(pair_b[7:0])) + 1)
        else $error("third mix not rounded");

    chk_midpoint: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && alpha_flag && sel == 2'h1
        |=> 32'(out_argb[15:8]) == (32'($past(pair_a[15:8])) + 32'($past(pair_b[15:8]))) / 2)
        else $error("average entry wrong");

    chk_rst_quiet: assert property (
        @(posedge core_clk)
        sys_rst |=> !out_valid && !out_fmt_ok && out_argb == 32'h00000000)
        else $error("outputs not cleared by reset");

    chk_answer_hold: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        !vld_r |=> $stable(out_argb) && $stable(out_fmt_ok))
        else $error("answer changed without request");

    chk_fmt_flag: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r |=> out_fmt_ok == $past(is_two_pair))
        else $error("format flag wrong");

    chk_base_fields: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r |-> col[0][7:3] == blk_r[`COL0_LSB + `BLUE_OFS +: 5]
            && col[3][23:19] == blk_r[`COL0_LSB + 3 * `COL_STRIDE + `RED_OFS +: 5])
        else $error("base colour field misplaced");

    chk_texel_index: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && texel_r == 5'h1F |-> sel == blk_r[`COL0_LSB - 1 -: 2])
        else $error("top texel index misplaced");

    chk_high_pair_base: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && upper_half && sel == 2'h0 |=> out_argb[23:0] == $past(col[2]))
        else $error("high texel not from colour 2");

    chk_direct_lsb: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r |-> col[3][10] == blk_r[`C3_GLSB_BIT] && col[1][10] == blk_r[`C1_GLSB_BIT])
        else $error("direct green bit wrong");

    chk_bit_replicate: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r |-> col[3][18:16] == col[3][23:21] && col[3][9:8] == col[3][15:14]
            && col[3][2:0] == col[3][7:5])
        else $error("channel replication wrong");

    // low table end is colour 1
    chk_low_pair_end: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && !upper_half && !alpha_flag && sel == 2'h3
        |=> out_argb[23:0] == $past(col[1]))
        else $error("low index 3 not colour 1");

    chk_third_high: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && upper_half && !alpha_flag && sel == 2'h2
        |=> 3 * 32'(out_argb[23:16]) <= 32'($past(col[2][23:16])) + 2 * 32'($past(col[3][23:16])) + 1
            && 3 * 32'(out_argb[23:16]) + 3 > 32'($past(col[2][23:16])) + 2 * 32'($past(col[3][23:16])) + 1)
        else $error("upper two-thirds mix not rounded");

    chk_third_upper: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && upper_half && !alpha_flag && sel == 2'h1
        |=> 3 * 32'(out_argb[15:8]) <= 2 * 32'($past(col[2][15:8])) + 32'($past(col[3][15:8])) + 1
            && 3 * 32'(out_argb[15:8]) + 3 > 2 * 32'($past(col[2][15:8])) + 32'($past(col[3][15:8])) + 1)
        else $error("upper one-third mix not rounded");

    chk_set_second: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && alpha_flag && sel == 2'h2
        |=> out_argb == {`ALPHA_OPAQUE, $past(upper_half ? col[3] : col[1])})
        else $error("flag-set index 2 wrong");

    chk_mid_upper: assert property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && alpha_flag && upper_half && sel == 2'h1
        |=> 2 * 32'(out_argb[23:16]) <= 32'($past(col[2][23:16])) + 32'($past(col[3][23:16]))
            && 2 * 32'(out_argb[23:16]) + 2 > 32'($past(col[2][23:16])) + 32'($past(col[3][23:16])))
        else $error("upper average wrong");

    cov_flag_clear: cover property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && !alpha_flag && sel == 2'h2 ##1 out_valid);

    cov_flag_set_black: cover property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_clear && upper_half ##1 out_valid);

    cov_back_to_back: cover property (
        @(posedge core_clk) disable iff (sys_rst)
        in_valid [*3] ##2 out_valid [*3]);

    cov_upper_third: cover property (
        @(posedge core_clk) disable iff (sys_rst)
        vld_r && is_two_pair && upper_half && !alpha_flag && sel == 2'h1 ##1 out_valid);

    cov_mid_reset: cover property (
        @(posedge core_clk)
        vld_r ##1 sys_rst);
endmodule : mixed_pair_texel_decoder

// ===== verif/texel_requester.sv
// Requester model: presents one block and texel number per cycle.
// Assumes the bench calls send and idle from its own process.
`timescale 1ns/1ps
module texel_requester
    import mixed_pair_pkg::*;
(
    input  wire logic               core_clk,
    output logic                    in_valid,
    output mixed_pair_pkg::block_t  in_block,
    output mixed_pair_pkg::texel_t  in_texel
);
    import mixed_pair_pkg::*;

    initial begin
        in_valid = 1'b0;
        in_block = '0;
        in_texel = '0;
    end

    // request set after a clock edge
    task automatic send(input block_t blk, input texel_t tx);
        @(negedge core_clk);
        in_valid <= 1'b1;
        in_block <= blk;
        in_texel <= tx;
    endtask : send

    task automatic idle();
        @(negedge core_clk);
        in_valid <= 1'b0;
        in_block <= ~in_block;
        in_texel <= ~in_texel;
    endtask : idle
endmodule : texel_requester

// ===== verif/tb_mixed_pair_texel_decoder.sv
// Self-checking bench for the two-pair texel decoder.
// Assumes a two-cycle answer latency and no back-pressure.
`timescale 1ns/1ps
module tb_mixed_pair_texel_decoder;
    import mixed_pair_pkg::*;
    typedef struct {int due; argb_t argb; logic fmt;} exp_t;
    logic   core_clk = 1'b0;
    logic   sys_rst  = 1'b1;
    logic   in_valid;
    block_t in_block;
    texel_t in_texel;
    logic   out_valid;
    argb_t  out_argb;
    logic   out_fmt_ok;
    int     cyc      = 0;
    int     fails    = 0;
    int     checked  = 0;
    exp_t   q[$];

    always #2 core_clk = ~core_clk;

    texel_requester i_req (.core_clk(core_clk), .in_valid(in_valid), .in_block(in_block), .in_texel(in_texel));

    mixed_pair_texel_decoder i_dut (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (in_valid),
        .in_block  (in_block),
        .in_texel  (in_texel),
        .out_valid (out_valid),
        .out_argb  (out_argb),
        .out_fmt_ok(out_fmt_ok)
    );

    // Expanded colour i of a block
    function automatic rgb_t ex(input block_t b, input int i);
        logic [14:0] f;
        logic        l;
        f = b[64 + 15 * i +: 15];
        l = (i == 3) ? b[126] : (i == 1) ? b[125] : (i == 2) ? b[33] ^ b[126] : b[1] ^ b[125];
        if (b[124] && !i[0])
            return {f[14:10], f[14:12], f[9:5], f[9:7], f[4:0], f[4:2]};
        return {f[14:10], f[14:12], f[9:5], l, f[9:8], f[4:0], f[4:2]};
    endfunction : ex

    function automatic argb_t ref_argb(input block_t b, input texel_t t);
        rgb_t       p;
        rgb_t       r;
        logic [1:0] s;
        logic [9:0] u;
        logic [9:0] v;
        p = ex(b, {t[4], 1'b0});
        r = ex(b, {t[4], 1'b1});
        s = b[2 * t +: 2];
        if (!b[127] || (b[124] && s == 2'h3))
            return '0;
        for (int k = 0; k < 3; k++) begin
            u = {2'h0, p[8 * k +: 8]};
            v = {2'h0, r[8 * k +: 8]};
            if (b[124])
                p[8 * k +: 8] = (s == 2'h0) ? u[7:0] : (s == 2'h1) ? 8'((u + v) >> 1) : v[7:0];
            else
                p[8 * k +: 8] = (s == 2'h0) ? u[7:0] : (s == 2'h1) ? 8'((2 * u + v + 1) / 3) :
                                (s == 2'h2) ? 8'((u + 2 * v + 1) / 3) : v[7:0];
        end
        return {8'hFF, p};
    endfunction : ref_argb

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    // Answer monitor
    always @(negedge core_clk) begin
        if (q.size() > 0 && (out_valid === 1'b1 || q[0].due == cyc)) begin
            cmp("valid", 32'(q[0].due == cyc), 32'(out_valid));
            cmp("argb", q[0].argb, out_argb);
            cmp("fmt", 32'(q[0].fmt), 32'(out_fmt_ok));
            void'(q.pop_front());
        end else if (out_valid !== 1'b0) begin
            cmp("spurious", 32'h0, 32'(out_valid));
        end
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic req(input block_t b, input texel_t t);
        i_req.send(b, t);
        q.push_back('{cyc + 2, ref_argb(b, t), b[127]});
    endtask : req

    task automatic run_block(input block_t b);
        for (int t = 0; t < 32; t++)
            req(b, t[4:0]);
        i_req.idle();
        repeat (6) @(negedge core_clk);
        cmp("drained", 32'h0, 32'(q.size()));
    endtask : run_block

    task automatic t_reset();
        cmp("rst argb", 32'h0, out_argb);
        cmp("rst flags", 32'h0, {30'h0, out_valid, out_fmt_ok});
        $display("test reset done");
    endtask : t_reset

    task automatic t_clear();
        for (int f = 0; f < 4; f++)
            run_block({1'b1, f[1:0], 1'b0, 60'hF0A5C39E127BD48, f[0] ? {16{4'hB}} : {16{4'h4}}});
        $display("test flag clear done");
    endtask : t_clear

    task automatic t_set();
        for (int f = 0; f < 4; f++)
            run_block({1'b1, f[1:0], 1'b1, f[0] ? 60'h0FFF8001F7C2A55 : 60'hF0A5C39E127BD48, 64'h1BE41BE41BE41BE4});
        $display("test flag set done");
    endtask : t_set

    task automatic t_non_fmt();
        run_block({4'h7, 60'h0FFF8001F7C2A55, 64'hE4E4E4E4E4E4E4E4});
        $display("test other format done");
    endtask : t_non_fmt

    // Request taken, then reset before its answer is due
    task automatic t_mid_reset();
        i_req.send({1'b1, 127'h0}, 5'h00);
        @(negedge core_clk);
        sys_rst <= 1'b1;
        i_req.idle();
        @(negedge core_clk);
        sys_rst <= 1'b0;
        cmp("mid rst flags", 32'h0, {30'h0, out_valid, out_fmt_ok});
        cmp("mid rst argb", 32'h0, out_argb);
        $display("test mid reset done");
    endtask : t_mid_reset

    initial begin
        repeat (3) @(negedge core_clk);
        sys_rst <= 1'b0;
        @(negedge core_clk);
        t_reset();
        t_clear();
        t_set();
        t_mid_reset();
        t_non_fmt();
        wrap_up();
    end
endmodule : tb_mixed_pair_texel_decoder
